/* core/wdk_regs.svh */
`ifndef WDK_REGS_SVH
`define WDK_REGS_SVH
// register byte addresses
`define WDK_CTRL_ADDR 12'h000
`define WDK_CAUSE_ADDR 12'h004
`define WDK_STAT_ADDR 12'h008
`define WDK_IRQ_ST_ADDR 12'h00c
`define WDK_IRQ_MASK_ADDR 12'h010
`define WDK_CMD_ADDR 12'h014
// control layout and reset value
`define WDK_CTRL_RESET 8'h53
`define WDK_KEY_DISABLE 5'h15
`define WDK_KEY_ENABLE 5'h0a
`define WDK_KEY_MSB 7
`define WDK_KEY_LSB 3
`define WDK_SEL_MSB 2
// overflow bit index for each timeout select code
`define WDK_EXP_SEL0 5'h08
`define WDK_EXP_SEL1 5'h0a
`define WDK_EXP_SEL2 5'h0c
`define WDK_EXP_SEL3 5'h0e
`define WDK_EXP_SEL4 5'h0f
`define WDK_EXP_SEL5 5'h10
`define WDK_EXP_SEL6 5'h11
`define WDK_EXP_SEL7 5'h12
// reset cause bit positions
`define WDK_CAUSE_WDKEY 0
`define WDK_CAUSE_LVKEY 1
`define WDK_CAUSE_LV 2
`define WDK_CAUSE_SELKEY 3
// command bits
`define WDK_CMD_CLR 0
`define WDK_CMD_HALT 1
// interrupt status bits
`define WDK_IRQ_TMO 0
`define WDK_IRQ_KEY 1
`endif

/* core/wdk_pkg.sv */
`default_nettype none
package wdk_pkg;
  typedef enum logic [1:0] {
    WDK_RUN = 2'b00,
    WDK_DELAY = 2'b01,
    WDK_FIRE = 2'b11
  } wdk_state_t;
endpackage
`default_nettype wire

/* core/wdk_div.sv */
`default_nettype none
// ---------------------------------------------
// oscillator tick divider
// ---------------------------------------------
module wdk_div #(
  parameter int unsigned DIV = 6250  // pclk cycles per oscillator tick
) (
  input wire logic pclk,     // system clock
  input wire logic presetn,  // async reset, active low
  input wire logic clr,      // restart phase
  output logic tick          // one-cycle enable
);
  logic [15:0] cnt_q;
  wire last = (cnt_q == 16'(DIV - 1));
  // tick on wrap; clear realigns so first period is whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end else begin
      cnt_q <= (clr || last) ? 16'h0000 : cnt_q + 16'h0001;
      tick <= last && !clr;
    end
  end
endmodule // wdk_div
`default_nettype wire

/* core/wdk_top.sv */
`default_nettype none
`include "wdk_regs.svh"
module wdk_top #(
  parameter int unsigned OSC_HZ = 32000,      // oscillator rate
  parameter int unsigned CLK_HZ = 200000000,  // pclk rate
  parameter int unsigned OSC_DIV = CLK_HZ / OSC_HZ, // pclk per tick
  parameter int unsigned SRESET_TICKS = 16    // soft reset delay, ticks
) (
  input wire logic pclk,              // apb clock
  input wire logic presetn,           // async reset, active low
  input wire logic psel,              // apb select
  input wire logic penable,           // apb enable
  input wire logic pwrite,            // apb direction
  input wire logic [11:0] paddr,      // apb byte address
  input wire logic [31:0] pwdata,     // apb write data
  output logic [31:0] prdata,         // apb read data
  output logic pready,                // apb ready
  output logic pslverr,               // apb error
  input wire logic sleep_mode,        // core is in sleep or idle
  input wire logic pin_reset_n,       // external reset pin, active low
  input wire logic pin_reset_sel,     // reset pin function selected
  input wire logic lvr_event,         // low voltage reset event
  input wire logic lvr_key_event,     // low voltage key reset event
  input wire logic rst_key_event,     // reset select key reset event
  output logic chip_reset,            // device reset pulse
  output logic pc_sp_reset,           // pc and sp reset pulse
  output logic pc_zero,               // program counter held to zero
  output logic irq                    // level interrupt
);
  // -------------------------------------------
  // bus decode
  // -------------------------------------------
  wire setup = psel && !penable;
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite;
  wire rd_map = (paddr == `WDK_CTRL_ADDR) || (paddr == `WDK_CAUSE_ADDR) ||
                (paddr == `WDK_STAT_ADDR) || (paddr == `WDK_IRQ_ST_ADDR) ||
                (paddr == `WDK_IRQ_MASK_ADDR) || (paddr == `WDK_CMD_ADDR);
  wire wr_ctrl = wr && (paddr == `WDK_CTRL_ADDR);
  wire wr_cause = wr && (paddr == `WDK_CAUSE_ADDR);
  wire wr_stat = wr && (paddr == `WDK_STAT_ADDR);
  wire wr_ist = wr && (paddr == `WDK_IRQ_ST_ADDR);
  wire wr_imask = wr && (paddr == `WDK_IRQ_MASK_ADDR);
  wire wr_cmd = wr && (paddr == `WDK_CMD_ADDR);
  wire cmd_clr = wr_cmd && pwdata[`WDK_CMD_CLR];
  wire cmd_halt = wr_cmd && pwdata[`WDK_CMD_HALT];

  // -------------------------------------------
  // state
  // -------------------------------------------
  logic [7:0] ctrl_q;
  logic [3:0] cause_q;
  logic expired_q, pdown_q;
  logic [1:0] ist_q, imask_q;
  logic [18:0] cnt_q;
  logic [7:0] dly_q;
  logic por_q;
  wdk_pkg::wdk_state_t st_q;
  logic tick;

  wire [4:0] key = ctrl_q[`WDK_KEY_MSB:`WDK_KEY_LSB];
  wire [2:0] sel = ctrl_q[`WDK_SEL_MSB:0];
  wire key_en = (key == `WDK_KEY_ENABLE);
  wire key_bad = !key_en && (key != `WDK_KEY_DISABLE);
  wire pin_rst = pin_reset_sel && !pin_reset_n;
  wire key_start = key_bad && (st_q == wdk_pkg::WDK_RUN);
  // any clearing source restarts count and divider phase
  wire cnt_clr = key_start || cmd_clr || cmd_halt || pin_rst;

  // overflow bit index per select code; a table is cheaper than a shifter
  logic [4:0] ovf_bit;
  always_comb begin
    case (sel)
      3'h0: ovf_bit = `WDK_EXP_SEL0;
      3'h1: ovf_bit = `WDK_EXP_SEL1;
      3'h2: ovf_bit = `WDK_EXP_SEL2;
      3'h3: ovf_bit = `WDK_EXP_SEL3;
      3'h4: ovf_bit = `WDK_EXP_SEL4;
      3'h5: ovf_bit = `WDK_EXP_SEL5;
      3'h6: ovf_bit = `WDK_EXP_SEL6;
      default: ovf_bit = `WDK_EXP_SEL7;
    endcase
  end
  wire ovf = key_en && tick && cnt_q[ovf_bit];

  // oscillator tick generator
  wdk_div #(.DIV(OSC_DIV)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .clr(cnt_clr),
    .tick(tick)
  );

  // -------------------------------------------
  // watchdog count
  // -------------------------------------------
  // cnt bit n set means 2^n ticks elapsed; overflow reloads to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 19'h00000;
    end else if (cnt_clr || ovf) begin
      cnt_q <= 19'h00000;
    end else if (key_en && tick) begin
      cnt_q <= cnt_q + 19'h00001;
    end
  end

  // -------------------------------------------
  // control register and key reset sequence
  // -------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `WDK_CTRL_RESET;
    end else if (st_q == wdk_pkg::WDK_FIRE) begin
      ctrl_q <= `WDK_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[7:0];
    end
  end

  // delay counts oscillator ticks; a bad key during delay does not re-arm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= wdk_pkg::WDK_RUN;
      dly_q <= 8'h00;
    end else begin
      case (st_q)
        wdk_pkg::WDK_RUN: begin
          dly_q <= 8'h00;
          if (key_bad) st_q <= wdk_pkg::WDK_DELAY;
        end
        wdk_pkg::WDK_DELAY: begin
          if (tick) dly_q <= dly_q + 8'h01;
          if (dly_q == 8'(SRESET_TICKS - 1) && tick)
            st_q <= wdk_pkg::WDK_FIRE;
        end
        wdk_pkg::WDK_FIRE: st_q <= wdk_pkg::WDK_RUN;
        default: st_q <= wdk_pkg::WDK_RUN;
      endcase
    end
  end
  wire key_fire = (st_q == wdk_pkg::WDK_FIRE);

  // -------------------------------------------
  // reset cause flags, set wins over clear
  // -------------------------------------------
  wire [3:0] cause_set = {rst_key_event, lvr_event, lvr_key_event,
                          key_fire};
  wire [3:0] cause_keep = wr_cause ? (cause_q & pwdata[3:0]) : cause_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= 4'h0;
    end else begin
      cause_q <= cause_keep | cause_set;
    end
  end

  // -------------------------------------------
  // status flags: expired and power-down
  // -------------------------------------------
  // clear command drops both; halt sets power-down and drops expired
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expired_q <= 1'b0;
      pdown_q <= 1'b0;
    end else begin
      if (ovf) expired_q <= 1'b1;
      else if (cmd_clr || cmd_halt || (wr_stat && !pwdata[0]))
        expired_q <= 1'b0;
      if (ovf && sleep_mode) pdown_q <= 1'b1;
      else if (cmd_halt) pdown_q <= 1'b1;
      else if (cmd_clr) pdown_q <= 1'b0;
    end
  end

  // -------------------------------------------
  // reset outputs
  // -------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_reset <= 1'b0;
      pc_sp_reset <= 1'b0;
      por_q <= 1'b1;
      pc_zero <= 1'b1;
    end else begin
      chip_reset <= (ovf && !sleep_mode) || key_fire;
      pc_sp_reset <= ovf && sleep_mode;
      por_q <= 1'b0;
      pc_zero <= por_q;
    end
  end

  // -------------------------------------------
  // interrupts, write one to clear, set wins
  // -------------------------------------------
  wire [1:0] ev = {key_fire, ovf};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= 2'h0;
      imask_q <= 2'h0;
      irq <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~(wr_ist ? pwdata[1:0] : 2'h0)) | ev;
      if (wr_imask) imask_q <= pwdata[1:0];
      irq <= |(ist_q & imask_q);
    end
  end

  // -------------------------------------------
  // apb slave: no wait states, error on unmapped
  // -------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      `WDK_CTRL_ADDR: rd_mux = {24'h000000, ctrl_q};
      `WDK_CAUSE_ADDR: rd_mux = {28'h0000000, cause_q};
      `WDK_STAT_ADDR: rd_mux = {30'h00000000, pdown_q, expired_q};
      `WDK_IRQ_ST_ADDR: rd_mux = {30'h00000000, ist_q};
      `WDK_IRQ_MASK_ADDR: rd_mux = {30'h00000000, imask_q};
      default: rd_mux = 32'h00000000;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup && !rd_map;
      prdata <= (setup && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // -------------------------------------------
  // checks
  // -------------------------------------------
  // a disabled watchdog must not drive either reset output unless a key reset is already firing
  key_dis_a: assert property (@(posedge pclk) disable iff (!presetn)
    (key == `WDK_KEY_DISABLE && !key_fire) |=> !chip_reset && !pc_sp_reset)
    else $error("reset while disabled");
  key_fire_a: assert property (@(posedge pclk) disable iff (!presetn)
    key_fire |=> chip_reset && cause_q[`WDK_CAUSE_WDKEY])
    else $error("bad key did not reset");
  key_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
    key_start |=> st_q == wdk_pkg::WDK_DELAY)
    else $error("bad key did not arm delay");
  key_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
    key_fire |=> ctrl_q == `WDK_CTRL_RESET)
    else $error("control not reloaded");
  cause_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cause_q[`WDK_CAUSE_WDKEY] && !wr_cause) |=> cause_q[`WDK_CAUSE_WDKEY])
    else $error("key flag lost");
  cause_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(cause_q[`WDK_CAUSE_WDKEY]) |->
      $past(wr_cause) && !$past(pwdata[`WDK_CAUSE_WDKEY]))
    else $error("key flag cleared by hardware");
  cause_ev_a: assert property (@(posedge pclk) disable iff (!presetn)
    lvr_event |=> cause_q[`WDK_CAUSE_LV])
    else $error("low voltage flag not set");
  tmo_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ovf && !sleep_mode) |=> chip_reset && expired_q && !pc_sp_reset)
    else $error("run overflow wrong");
  tmo_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ovf && sleep_mode) |=> pc_sp_reset && pdown_q && expired_q)
    else $error("sleep overflow wrong");
  halt_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_halt && !ovf) |=> pdown_q && !expired_q)
    else $error("halt flags wrong");
  clr_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_clr && !cmd_halt && !ovf) |=> !pdown_q && !expired_q)
    else $error("clear flags wrong");
  cnt_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_clr |=> cnt_q == 19'h00000)
    else $error("count not cleared");
  cnt_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    (key_en && tick && !cnt_clr && !ovf) |=>
      cnt_q == $past(cnt_q) + 19'h00001)
    else $error("count did not advance");
  cause_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && !pwrite && paddr == `WDK_CAUSE_ADDR) |-> prdata[31:4] == 0)
    else $error("cause upper bits set");
  cnt_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !key_en |=> $stable(cnt_q) || cnt_q == 19'h00000)
    else $error("disabled count moved");
  pc_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    !por_q |=> !pc_zero)
    else $error("pc zero held too long");
  // bus answer shape and interrupt level
  err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");
  err_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !rd_map) |=> pslverr)
    else $error("unmapped access not refused");
  irq_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|(ist_q & imask_q)) |=> irq)
    else $error("irq not raised");
  irq_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(|(ist_q & imask_q)) |=> !irq)
    else $error("irq not dropped");
endmodule // wdk_top
`default_nettype wire

/* verif/tb_top.sv */
`default_nettype none
`include "wdk_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sleep_mode = 1'b0;
  logic pin_reset_n = 1'b1;
  logic pin_reset_sel = 1'b0;
  logic lvr_event = 1'b0;
  logic lvr_key_event = 1'b0;
  logic rst_key_event = 1'b0;
  logic chip_reset;
  logic pc_sp_reset;
  logic pc_zero;
  logic irq;
  logic [31:0] rd;
  logic last_err;
  logic [2:0] sel;
  int errors = 0;
  int n_checks = 0;
  int n_rst = 0;
  int n_pcsp = 0;
  int waited;
  int exp_c;
  int base_rst;

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // small divider values keep the timeouts within a short run
  wdk_top #(.OSC_DIV(2), .SRESET_TICKS(2)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
    .pin_reset_n(pin_reset_n), .pin_reset_sel(pin_reset_sel),
    .lvr_event(lvr_event), .lvr_key_event(lvr_key_event),
    .rst_key_event(rst_key_event), .chip_reset(chip_reset),
    .pc_sp_reset(pc_sp_reset), .pc_zero(pc_zero), .irq(irq)
  );

  // reset pulses are one cycle wide, so count them at every edge
  always @(posedge pclk) begin
    if (chip_reset === 1'b1) n_rst++;
    if (pc_sp_reset === 1'b1) n_pcsp++;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n == 50) errors++;
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // bounded wait for the next chip or pc/sp reset pulse
  task automatic wait_ev(input bit pcsp, input int max);
    int base;
    base = pcsp ? n_pcsp : n_rst;
    waited = 0;
    while ((pcsp ? n_pcsp : n_rst) == base && waited < max) begin
      @(posedge pclk);
      waited++;
    end
  endtask

  task automatic quiet(input int n);
    int base;
    base = n_rst + n_pcsp;
    repeat (n) @(posedge pclk);
    chk(n_rst + n_pcsp - base, 32'h0);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    chk({31'h0, pc_zero}, 32'h1);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, pc_zero}, 32'h0);
    rdc(`WDK_CTRL_ADDR, 32'h53);
    rdc(`WDK_CAUSE_ADDR, 32'h0);
    // the three external flag sources together set cause bits 1 to 3
    lvr_event <= 1'b1;
    lvr_key_event <= 1'b1;
    rst_key_event <= 1'b1;
    @(posedge pclk);
    lvr_event <= 1'b0;
    lvr_key_event <= 1'b0;
    rst_key_event <= 1'b0;
    @(posedge pclk);
    rdc(`WDK_CAUSE_ADDR, 32'he);
    wr(`WDK_CAUSE_ADDR, 32'hff);
    rdc(`WDK_CAUSE_ADDR, 32'he);
    wr(`WDK_CAUSE_ADDR, 32'h0);
    rdc(`WDK_CAUSE_ADDR, 32'h0);
    rdc(12'h020, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    rdc(`WDK_CMD_ADDR, 32'h0);
    // timeout length for the three shortest selections
    for (int s = 0; s < 3; s++) begin
      sel = 3'(s);
      exp_c = (1 << (8 + 2 * s)) * 2;
      wr(`WDK_CTRL_ADDR, {24'h0, 5'h0a, sel});
      wr(`WDK_CMD_ADDR, 32'h1);
      wait_ev(1'b0, exp_c * 2);
      chk(32'(waited > exp_c * 9 / 10 && waited < exp_c * 11 / 10),
          32'h1);
      rdc(`WDK_STAT_ADDR, 32'h1);
    end
    chk({31'h0, irq}, 32'h0);
    wr(`WDK_IRQ_MASK_ADDR, 32'h3);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(`WDK_IRQ_ST_ADDR, 32'h1);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(`WDK_CMD_ADDR, 32'h2);
    rdc(`WDK_STAT_ADDR, 32'h2);
    // asleep: only pc and sp are reset
    sleep_mode <= 1'b1;
    base_rst = n_rst;
    wait_ev(1'b1, 10000);
    chk(32'(waited < 10000), 32'h1);
    chk(n_rst - base_rst, 32'h0);
    sleep_mode <= 1'b0;
    rdc(`WDK_STAT_ADDR, 32'h3);
    wr(`WDK_CMD_ADDR, 32'h1);
    rdc(`WDK_STAT_ADDR, 32'h0);
    wr(`WDK_IRQ_ST_ADDR, 32'h3);
    // periodic clearing keeps the shortest timeout from expiring
    wr(`WDK_CTRL_ADDR, 32'h50);
    waited = n_rst;
    repeat (6) begin
      repeat (300) @(posedge pclk);
      wr(`WDK_CMD_ADDR, 32'h1);
    end
    chk(n_rst - waited, 32'h0);
    pin_reset_sel <= 1'b1;
    pin_reset_n <= 1'b0;
    quiet(1500);
    pin_reset_n <= 1'b1;
    pin_reset_sel <= 1'b0;
    wr(`WDK_CTRL_ADDR, 32'ha8);
    rdc(`WDK_CTRL_ADDR, 32'ha8);
    quiet(1500);
    wr(`WDK_CMD_ADDR, 32'h2);
    quiet(1500);
    // invalid key: delayed reset, flag and reload
    wr(`WDK_CTRL_ADDR, 32'h0);
    wait_ev(1'b0, 200);
    chk(32'(waited < 200), 32'h1);
    rdc(`WDK_CAUSE_ADDR, 32'h1);
    rdc(`WDK_CTRL_ADDR, 32'h53);
    rdc(`WDK_IRQ_ST_ADDR, 32'h2);
    wr(`WDK_CAUSE_ADDR, 32'h0);
    rdc(`WDK_CAUSE_ADDR, 32'h0);
    close_out();
  end

  // hang guard, well beyond the longest expected run
  initial begin
    #300000;
    errors++;
    close_out();
  end
endmodule // tb_top
`default_nettype wire
